// ### common/tarc_pkg.sv
`default_nettype none
package tarc_pkg;
  // condition slots
  localparam int N_COND = 8;
  localparam int COND_OVER_TEMP = 0;
  localparam int COND_FAST_OVERCURRENT = 1;
  localparam int COND_POWER_FAULT = 2;
  localparam int COND_COOLANT_LEVEL = 3;
  localparam int COND_RTD_SENSOR = 4;
  localparam int COND_THERMISTOR = 5;
  localparam int COND_EXT_MOTOR_HEAT = 6;
  localparam int COND_COMM_ERROR = 7;
  // attempt limit range
  localparam int LIMIT_W = 4;
  localparam logic [3:0] LIMIT_OFF = 4'h0;
  localparam logic [3:0] LIMIT_MAX = 4'hA;
  localparam logic [3:0] CNT_SAT = 4'hB;
  // per-condition delay, seconds
  localparam int DELAY_W = 12;
  localparam logic [11:0] DELAY_OFF = 12'h000;
  localparam logic [11:0] DELAY_MAX = 12'hE10;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int PRESC_W = 25;
  localparam int QUIET_MINUTES = 10;
  localparam int SEC_PER_MIN = 60;
  localparam int QUIET_SEC = QUIET_MINUTES * SEC_PER_MIN;
  localparam int QUIET_W = 10;
  localparam logic [9:0] QUIET_LAST = 10'(QUIET_SEC - 1);
endpackage
`default_nettype wire

// ### design/tarc_top.sv
// Overview of operation
// [R1] limit 0..10; zero disables auto reset
// [R2] auto restart only with all faults gone
// [R3] counter above limit aborts auto reset
// [R4] ten quiet minutes decrement attempt counter
// [R5] limit exceeded marks log; manual reset works
// [R6] remote low-then-high zeroes attempt counter
// [R7] remote input held high enables auto reset
// [R8] auto reset waits for ramp to finish
// [R9] delay 0 excludes condition, else seconds
// [R10] delay starts after fault clears, then clears
// [R11] eight conditions, own delay and timer
// [R12] unselected trips stay latched until reset
// [R13] no restart without a reset command
// [R14] remote reset level or rising-edge selectable
// [R15] every trip restarts the quiet timer
`default_nettype none
module tarc_top
  import tarc_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [LIMIT_W-1:0] trip_attempt_limit,
  input wire logic level_edge_sel,
  input wire logic remote_reset_pin,
  input wire logic manual_reset,
  input wire logic ramp_remaining,
  input wire logic [N_COND-1:0] fault_active,
  input wire logic [DELAY_W-1:0] over_temp_reset_delay,
  input wire logic [DELAY_W-1:0] fast_overcurrent_reset_delay,
  input wire logic [DELAY_W-1:0] power_fault_reset_delay,
  input wire logic [DELAY_W-1:0] coolant_level_reset_delay,
  input wire logic [DELAY_W-1:0] rtd_sensor_reset_delay,
  input wire logic [DELAY_W-1:0] thermistor_reset_delay,
  input wire logic [DELAY_W-1:0] external_motor_heat_reset_delay,
  input wire logic [DELAY_W-1:0] comm_error_reset_delay,
  output logic [N_COND-1:0] alarm_latched,
  output logic restart_permit,
  output logic auto_restart_pulse,
  output logic auto_reset_aborted,
  output logic log_auto_mark
);

  // delay settings gathered by slot
  logic [DELAY_W-1:0] delay_in [N_COND];
  // delays after clamping to the legal range
  logic [DELAY_W-1:0] dly_eff [N_COND];
  // per-slot seconds timers
  logic [DELAY_W-1:0] tmr_reg [N_COND];
  // latched alarms
  logic [N_COND-1:0] alarm_reg;
  // slots ready to be auto cleared this cycle
  logic [N_COND-1:0] clear_vec;
  // remote input synchroniser and edge history
  logic rr_meta_reg;
  logic rr_sync_reg;
  logic rr_prev_reg;
  logic [1:0] rr_fill_reg; // marks the synchroniser as filled after reset
  logic rr_rise;
  // seconds prescaler
  logic [PRESC_W-1:0] presc_reg;
  logic sec_tick;
  // quiet-period seconds counter
  logic [QUIET_W-1:0] quiet_reg;
  logic quiet_done;
  // hidden attempt counter
  logic [LIMIT_W-1:0] cnt_reg;
  logic [LIMIT_W-1:0] cnt_inc;
  logic [LIMIT_W-1:0] limit_eff;
  // decoded conditions
  logic auto_enabled;
  logic abort;
  logic auto_go;
  logic trip_event;
  logic remote_cmd;
  logic reset_cmd;
  // output flops
  logic auto_clear_reg;
  logic aborted_reg;
  logic mark_reg;

  assign delay_in[COND_OVER_TEMP] = over_temp_reset_delay;
  assign delay_in[COND_FAST_OVERCURRENT] = fast_overcurrent_reset_delay;
  assign delay_in[COND_POWER_FAULT] = power_fault_reset_delay;
  assign delay_in[COND_COOLANT_LEVEL] = coolant_level_reset_delay;
  assign delay_in[COND_RTD_SENSOR] = rtd_sensor_reset_delay;
  assign delay_in[COND_THERMISTOR] = thermistor_reset_delay;
  assign delay_in[COND_EXT_MOTOR_HEAT] = external_motor_heat_reset_delay;
  assign delay_in[COND_COMM_ERROR] = comm_error_reset_delay;

  // remote pin is asynchronous: two flops before any use; edge history reads
  // only the second flop and stays high until the pipe has filled, so a
  // contact already closed at reset is no edge (one closed during reset is lost)
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rr_meta_reg <= 1'b0;
      rr_sync_reg <= 1'b0;
      rr_fill_reg <= 2'h0;
      rr_prev_reg <= 1'b1;
    end else begin
      rr_meta_reg <= remote_reset_pin;
      rr_sync_reg <= rr_meta_reg;
      rr_fill_reg <= {rr_fill_reg[0], 1'b1};
      rr_prev_reg <= rr_fill_reg[1] ? rr_sync_reg : 1'b1;
    end
  end

  assign rr_rise = rr_sync_reg & ~rr_prev_reg;

  // out-of-range limits saturate at the top of the range
  assign limit_eff = (trip_attempt_limit > LIMIT_MAX) ? LIMIT_MAX : trip_attempt_limit; // R1

  // held-high remote input is the enable level
  assign auto_enabled = (limit_eff != LIMIT_OFF) && rr_sync_reg; // R1 R7

  // more trips than allowed: no more automatic clears
  assign abort = cnt_reg > limit_eff; // R3

  // ramp must be over and every monitored input normal
  assign auto_go = auto_enabled && !abort && !ramp_remaining && (fault_active == '0); // R2 R8

  // a trip is a fault on a slot not already latched
  assign trip_event = |(fault_active & ~alarm_reg);

  // level mode doubles as auto enable, so it resets only with auto reset off
  assign remote_cmd = level_edge_sel ? rr_rise :
    (rr_sync_reg && (limit_eff == LIMIT_OFF)); // R14

  assign reset_cmd = manual_reset | remote_cmd; // R13

  // free-running seconds tick
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      presc_reg <= '0;
    end else if (presc_reg == PRESC_W'(SEC_CYCLES - 1)) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + PRESC_W'(1);
    end
  end

  assign sec_tick = presc_reg == PRESC_W'(SEC_CYCLES - 1);

  // quiet timer: any trip starts the interval over
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      quiet_reg <= '0;
    end else if (trip_event) begin
      quiet_reg <= '0; // R15
    end else if (quiet_done) begin
      quiet_reg <= '0; // R4
    end else if (sec_tick) begin
      quiet_reg <= quiet_reg + QUIET_W'(1);
    end
  end

  assign quiet_done = sec_tick && (quiet_reg == QUIET_LAST);

  // saturating so a long burst cannot wrap back under the limit
  assign cnt_inc = (cnt_reg == CNT_SAT) ? CNT_SAT : cnt_reg + LIMIT_W'(1);

  // attempt counter; a counted trip outranks decay, and with a rearm in the same cycle it counts from zero to 1
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (trip_event && auto_enabled) begin
      cnt_reg <= rr_rise ? LIMIT_W'(1) : cnt_inc;
    end else if (rr_rise) begin
      cnt_reg <= '0; // R6
    end else if (quiet_done && (cnt_reg != '0)) begin
      cnt_reg <= cnt_reg - LIMIT_W'(1); // R4
    end
  end

  // log marker: set wins over the rearm clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mark_reg <= 1'b0;
    end else if (trip_event && auto_enabled && (cnt_inc > limit_eff)) begin
      mark_reg <= 1'b1; // R5
    end else if (rr_rise) begin
      mark_reg <= 1'b0; // R6
    end
  end

  // registered copies for the outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aborted_reg <= 1'b0;
      auto_clear_reg <= 1'b0;
    end else begin
      aborted_reg <= abort;
      auto_clear_reg <= |clear_vec;
    end
  end

  // one latch, delay and timer per condition
  for (genvar i = 0; i < N_COND; i++) begin : g_cond
    logic armed;

    // oversize settings act as the longest delay
    assign dly_eff[i] = (delay_in[i] > DELAY_MAX) ? DELAY_MAX : delay_in[i]; // R9

    // timer runs only after the fault is gone; off slots never arm
    assign armed = alarm_reg[i] && !fault_active[i] && (dly_eff[i] != DELAY_OFF); // R9 R10 R11

    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        tmr_reg[i] <= '0;
      end else if (!armed) begin
        tmr_reg[i] <= '0; // R10
      end else if (sec_tick && (tmr_reg[i] != dly_eff[i])) begin
        tmr_reg[i] <= tmr_reg[i] + DELAY_W'(1); // R10
      end
    end

    assign clear_vec[i] = armed && (tmr_reg[i] == dly_eff[i]) && auto_go; // R2 R10 R12

    // fault presence sets and wins over any clear
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        alarm_reg[i] <= 1'b0;
      end else if (fault_active[i]) begin
        alarm_reg[i] <= 1'b1;
      end else if (clear_vec[i] || reset_cmd) begin
        alarm_reg[i] <= 1'b0; // R12 R13
      end
    end

    // an auto clear needs a nonzero delay fully counted
    property p_auto_clear_delay;
      @(posedge clock) disable iff (reset)
        $fell(alarm_reg[i]) && !$past(reset_cmd)
        |-> ($past(dly_eff[i]) != DELAY_OFF) && ($past(tmr_reg[i]) == $past(dly_eff[i]));
    endproperty
    a_auto_clear_delay: assert property (p_auto_clear_delay) // R9 R10
      else $error("alarm cleared before its delay");

    // timer stays at zero while the fault is present
    property p_timer_waits;
      @(posedge clock) disable iff (reset)
        fault_active[i] |=> tmr_reg[i] == '0;
    endproperty
    a_timer_waits: assert property (p_timer_waits) // R10
      else $error("delay counted while fault present");
  end

  assign alarm_latched = alarm_reg;
  // restart only once every latched alarm has been cleared
  assign restart_permit = (alarm_reg == '0); // R13
  assign auto_restart_pulse = auto_clear_reg;
  assign auto_reset_aborted = aborted_reg;
  assign log_auto_mark = mark_reg;

  // auto clear only while enabled by limit and remote level
  property p_enable_needed;
    @(posedge clock) disable iff (reset)
      auto_clear_reg |-> $past(limit_eff != LIMIT_OFF) && $past(rr_sync_reg);
  endproperty
  a_enable_needed: assert property (p_enable_needed) // R1 R7
    else $error("auto clear without enable");

  property p_all_normal;
    @(posedge clock) disable iff (reset)
      auto_clear_reg |-> $past(fault_active) == '0;
  endproperty
  a_all_normal: assert property (p_all_normal) // R2
    else $error("auto clear with a fault present");

  property p_abort_blocks;
    @(posedge clock) disable iff (reset)
      auto_clear_reg |-> !$past(abort);
  endproperty
  a_abort_blocks: assert property (p_abort_blocks) // R3
    else $error("auto clear after abort");

  property p_decay;
    @(posedge clock) disable iff (reset)
      quiet_done && !trip_event && !rr_rise && (cnt_reg != '0)
      |=> cnt_reg == $past(cnt_reg) - LIMIT_W'(1);
  endproperty
  a_decay: assert property (p_decay) // R4
    else $error("attempt counter did not decay");

  property p_mark;
    @(posedge clock) disable iff (reset)
      trip_event && auto_enabled && (cnt_inc > limit_eff) |=> log_auto_mark;
  endproperty
  a_mark: assert property (p_mark) // R5
    else $error("log marker missing");

  property p_rearm;
    @(posedge clock) disable iff (reset)
      rr_rise && !trip_event |=> (cnt_reg == '0) ##1 !aborted_reg;
  endproperty
  a_rearm: assert property (p_rearm) // R6
    else $error("rearm did not zero counter");

  property p_ramp_wait;
    @(posedge clock) disable iff (reset)
      ramp_remaining |=> !auto_restart_pulse;
  endproperty
  a_ramp_wait: assert property (p_ramp_wait) // R8
    else $error("auto reset during ramp");

  property p_clear_cause;
    @(posedge clock) disable iff (reset)
      $rose(restart_permit) |-> $past(reset_cmd) || $past(|clear_vec);
  endproperty
  a_clear_cause: assert property (p_clear_cause) // R13
    else $error("restart without reset command");

  property p_edge_mode;
    @(posedge clock) disable iff (reset)
      level_edge_sel && remote_cmd |-> rr_sync_reg && !rr_prev_reg;
  endproperty
  a_edge_mode: assert property (p_edge_mode) // R14
    else $error("edge mode reset without rising edge");

  property p_quiet_restart;
    @(posedge clock) disable iff (reset)
      trip_event |=> quiet_reg == '0;
  endproperty
  a_quiet_restart: assert property (p_quiet_restart) // R15
    else $error("quiet timer not restarted by trip");

  // main scenarios
  c_auto_clear: cover property (@(posedge clock) disable iff (reset) auto_restart_pulse);
  c_abort: cover property (@(posedge clock) disable iff (reset) $rose(auto_reset_aborted));
  c_rearm: cover property (@(posedge clock) disable iff (reset) rr_rise && log_auto_mark);
  c_decay: cover property (@(posedge clock) disable iff (reset) quiet_done && cnt_reg != '0);

endmodule // tarc_top
`default_nettype wire

// ### bench/tarc_far_side.sv
`default_nettype none
// far side model: drive trip sources and the remote reset contact
module tarc_far_side
  import tarc_pkg::*;
(
  input wire logic clock,
  input wire logic [N_COND-1:0] fault_cmd,
  input wire logic remote_cmd,
  output logic [N_COND-1:0] fault_active,
  output logic remote_reset_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet plant at power-up, contact open
  initial begin
    fault_active = 8'h00;
    remote_reset_pin = 1'b0;
  end
  // faults follow the command one edge late, like a slow sensor
  always @(posedge clock) begin
    fault_active <= #5 fault_cmd;
  end
  // contact held high arms auto reset; low then high re-arms it
  always @(posedge clock) begin
    remote_reset_pin <= #5 remote_cmd;
  end
endmodule // tarc_far_side
`default_nettype wire

// ### bench/tarc_top_tb.sv
`default_nettype none
module tarc_top_tb
  import tarc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC_CYC = 4; // short seconds keep the run brief
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [LIMIT_W-1:0] limit_cfg = 4'h0; // attempt limit
  logic edge_sel = 1'b0; // remote mode
  logic manual_reset = 1'b0;
  logic ramp_remaining = 1'b0;
  logic [N_COND-1:0] fault_cmd = 8'h00; // wish list for the far side
  logic remote_cmd = 1'b1; // contact held high from the start
  logic [DELAY_W-1:0] dly [N_COND]; // per-slot delays, cleared at time zero
  wire [N_COND-1:0] fault_active;
  wire remote_pin;
  logic [N_COND-1:0] alarm;
  logic permit;
  logic pulse;
  logic aborted;
  logic mark;
  int num_errors = 0;
  int check_count = 0;
  // free-running 20 MHz clock
  always #25 clock = ~clock;
  tarc_far_side far (.clock(clock), .fault_cmd(fault_cmd), .remote_cmd(remote_cmd),
    .fault_active(fault_active), .remote_reset_pin(remote_pin));
  tarc_top #(.SEC_CYCLES(SEC_CYC)) dut (.clock(clock), .reset(reset),
    .trip_attempt_limit(limit_cfg), .level_edge_sel(edge_sel),
    .remote_reset_pin(remote_pin), .manual_reset(manual_reset),
    .ramp_remaining(ramp_remaining), .fault_active(fault_active),
    .over_temp_reset_delay(dly[0]), .fast_overcurrent_reset_delay(dly[1]),
    .power_fault_reset_delay(dly[2]), .coolant_level_reset_delay(dly[3]),
    .rtd_sensor_reset_delay(dly[4]), .thermistor_reset_delay(dly[5]),
    .external_motor_heat_reset_delay(dly[6]), .comm_error_reset_delay(dly[7]),
    .alarm_latched(alarm), .restart_permit(permit), .auto_restart_pulse(pulse),
    .auto_reset_aborted(aborted), .log_auto_mark(mark));
  // verdict and end of run, shared with the watchdog
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // n rising edges, then settle past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  // four-state compare so an unknown never matches
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // fault seen by the device for one edge only
  task automatic trip(input logic [7:0] slots);
    fault_cmd = slots;
    step(1);
    fault_cmd = 8'h00;
    step(3);
  endtask
  // bounded wait for one slot to drop; stops on the first low cycle
  task automatic wait_clear(input int i, input int n);
    int k;
    k = 0;
    while (alarm[i] !== 1'b0 && k < n) begin
      step(1);
      k++;
    end
  endtask
  // one-cycle panel reset command
  task automatic press_reset();
    manual_reset = 1'b1;
    step(1);
    manual_reset = 1'b0;
    step(2);
  endtask
  // contact low long enough to pass the synchroniser, then high again
  task automatic rearm();
    remote_cmd = 1'b0;
    step(4);
    remote_cmd = 1'b1;
    step(5);
  endtask
  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #(20000 * 50);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    for (int i = 0; i < N_COND; i++) dly[i] = 12'h000; // all slots off in reset
    step(3);
    reset = 1'b0;
    chk(alarm, 8'h00, "alarms after reset");
    chk({permit, pulse, aborted, mark}, 8'h08, "flags after reset");
    // slot i waits i seconds; slot 0 is excluded
    limit_cfg = 4'hA;
    for (int i = 0; i < N_COND; i++) dly[i] = 12'(i);
    fault_cmd = 8'hFF;
    step(6);
    fault_cmd = 8'h00;
    step(1);
    chk(alarm, 8'hFF, "alarms held as faults go");
    for (int i = 1; i < N_COND; i++) begin
      wait_clear(i, 4 * i + 12);
      chk(alarm, 8'(8'hFE << i) | 8'h01, "slots clear in delay order");
      chk(pulse, 1'b1, "restart pulse with clear");
    end
    chk(permit, 1'b0, "excluded slot blocks restart");
    press_reset();
    chk(alarm, 8'h00, "manual reset clears excluded slot");
    chk(permit, 1'b1, "restart allowed again");
    $display("test delays done");
    // remaining ramp time postpones the clear
    ramp_remaining = 1'b1;
    trip(8'h02);
    step(30);
    chk(alarm, 8'h02, "ramp holds the clear");
    ramp_remaining = 1'b0;
    wait_clear(1, 8);
    chk(alarm, 8'h00, "clear once ramp ends");
    $display("test ramp done");
    // limit 2: third trip aborts, marks, then decays after quiet time
    limit_cfg = 4'h2;
    rearm();
    for (int t = 0; t < 2; t++) begin
      trip(8'h02);
      wait_clear(1, 12);
      chk(alarm, 8'h00, "attempt within limit clears");
    end
    step(1500);
    trip(8'h02);
    step(2);
    chk({aborted, mark}, 8'h03, "abort and marker on third trip");
    step(40);
    chk(alarm, 8'h02, "no auto clear once aborted");
    press_reset();
    chk(alarm, 8'h00, "manual reset still clears");
    step(2250);
    chk(aborted, 1'b1, "quiet time restarted by last trip");
    step(150);
    chk(aborted, 1'b0, "decay after ten quiet minutes");
    rearm();
    chk({aborted, mark}, 8'h00, "re-arm clears marker");
    $display("test attempts done");
    // remote low: no auto clear although a limit is set
    remote_cmd = 1'b0;
    edge_sel = 1'b1;
    step(4);
    trip(8'h02);
    step(30);
    chk(alarm, 8'h02, "remote low disables auto clear");
    // limit 0: no auto clear; remote acts as reset command
    limit_cfg = 4'h0;
    step(30);
    chk(alarm, 8'h02, "limit zero disables auto clear");
    remote_cmd = 1'b1;
    step(6);
    chk(alarm, 8'h00, "rising edge resets");
    trip(8'h02);
    step(20);
    chk(alarm, 8'h02, "edge mode ignores held level");
    edge_sel = 1'b0;
    step(6);
    chk(alarm, 8'h00, "level mode resets on held high");
    $display("test remote modes done");
    test_done();
  end
endmodule // tarc_top_tb
`default_nettype wire
